// *** core/rx_alarm_link_irq_map.vh ***
// Purpose: constants for the receive alarm-code and link interrupt/control block
// Assumes: byte-wide microprocessor register port, offsets as index values
// Notes: Operation list below
// Operation
// - valid flag follows alarm code validated/removed
// - removal interrupt when enabled and code removed
// - removal status sticky, cleared on read
// - validation interrupt when enabled and code validated
// - validation status sticky, cleared on read
// - alarm-code bits act only in C-bit parity
// - five search-block enables, default all on
// - link controller runs only when enabled, default off
// - link interrupt on each new message when enabled
// - link status sticky since last read, cleared on read
// - link bits act only in C-bit parity
// - hold last validated six-bit alarm code
`ifndef RX_ALARM_LINK_IRQ_MAP_VH
`define RX_ALARM_LINK_IRQ_MAP_VH
`define ADDR_CODE_WORD 8'h12
`define ADDR_ALARM_IRQ 8'h13
`define ADDR_LINK_CTRL 8'h14
`define ALARM_VALID_BIT 4
`define ALARM_REM_EN_BIT 3
`define ALARM_REM_ST_BIT 2
`define ALARM_VAL_EN_BIT 1
`define ALARM_VAL_ST_BIT 0
`define LINK_EN_BIT 2
`define LINK_IRQ_EN_BIT 1
`define LINK_ST_BIT 0
`define SEARCH_EN_LSB 3
`define SEARCH_EN_RESET 5'h1F
`define CODE_WORD_RESET 6'h3F
`endif

// *** core/sticky_read_clear.v ***
// Purpose: one sticky status bit set by an event, cleared by a read
// Assumes: event and read are on core_clk_i
// Notes: set wins over the clear in the same cycle
`timescale 1ns/10ps
module sticky_read_clear (
    input wire core_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire set_i,
    input wire clear_i,
    output reg flag_q
);
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (clk_en_i) begin
            if (set_i) begin
                flag_q <= 1'b1;
            end else if (clear_i) begin
                flag_q <= 1'b0;
            end
        end
    end
endmodule // sticky_read_clear

// *** core/rx_alarm_link_irq.v ***
// Purpose: receive alarm-code and path maintenance link interrupt/control registers
// Assumes: byte microprocessor port, one-cycle read/write strobes on core_clk_i
// Notes: events come from framer logic on the same clock, so no synchronisers
`timescale 1ns/10ps
`include "rx_alarm_link_irq_map.vh"
module rx_alarm_link_irq (
    input wire core_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire cbit_parity_i,
    input wire code_valid_i,
    input wire [5:0] code_word_i,
    input wire link_msg_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    output reg irq_o,
    output reg [4:0] search_en_o,
    output reg link_run_o
);
    reg valid_q;
    reg [5:0] received_alarm_code_word_q;
    reg rem_en_q;
    reg val_en_q;
    reg link_en_q;
    reg link_irq_en_q;
    reg [7:0] rdata_d;
    wire rem_st;
    wire val_st;
    wire link_st;
    wire valid_d;
    wire val_evt;
    wire rem_evt;
    wire link_evt;
    wire rd_alarm;
    wire rd_link;
    wire wr_link;
    wire wr_alarm;
    wire irq_d;
    wire hit_code;
    wire hit_alarm;
    wire hit_link;
    wire rem_irq_term;
    wire val_irq_term;
    wire link_irq_term;
    wire [5:0] code_word_rev;
    wire [7:0] code_word_image;
    wire [7:0] alarm_image;
    wire [7:0] link_image;
    genvar bit_idx;

    // alarm code tracking only in C-bit parity mode
    assign valid_d = cbit_parity_i & code_valid_i;
    assign val_evt = valid_d & ~valid_q;
    assign rem_evt = ~valid_d & valid_q;
    assign link_evt = cbit_parity_i & link_en_q & link_msg_i;
    assign rd_alarm = rd_i & (addr_i == `ADDR_ALARM_IRQ);
    assign rd_link = rd_i & (addr_i == `ADDR_LINK_CTRL);
    assign wr_alarm = wr_i & (addr_i == `ADDR_ALARM_IRQ);
    assign wr_link = wr_i & (addr_i == `ADDR_LINK_CTRL);

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            received_alarm_code_word_q <= `CODE_WORD_RESET;
        end else if (clk_en_i) begin
            valid_q <= valid_d;
            if (val_evt) begin
                received_alarm_code_word_q <= code_word_i;
            end
        end
    end

    sticky_read_clear u_rem_st (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .set_i(rem_evt),
        .clear_i(rd_alarm),
        .flag_q(rem_st)
    );

    sticky_read_clear u_val_st (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .set_i(val_evt),
        .clear_i(rd_alarm),
        .flag_q(val_st)
    );

    sticky_read_clear u_link_st (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .set_i(link_evt),
        .clear_i(rd_link),
        .flag_q(link_st)
    );

    // address hits, shared by the read mux
    assign hit_code = (addr_i == `ADDR_CODE_WORD);
    assign hit_alarm = (addr_i == `ADDR_ALARM_IRQ);
    assign hit_link = (addr_i == `ADDR_LINK_CTRL);

    // removal interrupt enable
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rem_en_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_alarm) begin
                rem_en_q <= wdata_i[`ALARM_REM_EN_BIT];
            end
        end
    end

    // validation interrupt enable
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            val_en_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_alarm) begin
                val_en_q <= wdata_i[`ALARM_VAL_EN_BIT];
            end
        end
    end

    // link controller enable, off after reset
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            link_en_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_link) begin
                link_en_q <= wdata_i[`LINK_EN_BIT];
            end
        end
    end

    // link message interrupt enable
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            link_irq_en_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_link) begin
                link_irq_en_q <= wdata_i[`LINK_IRQ_EN_BIT];
            end
        end
    end

    // five f-bit search block enables, all on after reset
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            search_en_o <= `SEARCH_EN_RESET;
        end else if (clk_en_i) begin
            if (wr_link) begin
                search_en_o <= wdata_i[`SEARCH_EN_LSB+4:`SEARCH_EN_LSB];
            end
        end
    end

    // link controller runs only when enabled in C-bit parity
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            link_run_o <= 1'b0;
        end else if (clk_en_i) begin
            link_run_o <= link_en_q & cbit_parity_i;
        end
    end

    // per-source interrupt terms
    assign rem_irq_term = rem_en_q & rem_st;
    assign val_irq_term = val_en_q & val_st;
    assign link_irq_term = link_irq_en_q & link_st;

    // level interrupt, masked outside C-bit parity
    assign irq_d = cbit_parity_i & (rem_irq_term | val_irq_term | link_irq_term);

    // code word is shown with its bit 0 in the highest used position
    generate
        for (bit_idx = 0; bit_idx < 6; bit_idx = bit_idx + 1) begin : g_word_rev
            assign code_word_rev[5 - bit_idx] = received_alarm_code_word_q[bit_idx];
        end
    endgenerate

    // register images as the host sees them
    assign code_word_image = {1'b0, code_word_rev, 1'b0};
    assign alarm_image = {3'h0, valid_q, rem_en_q, rem_st, val_en_q, val_st};
    assign link_image = {search_en_o, link_en_q, link_irq_en_q, link_st};

    // read mux, unmapped addresses read as zero
    always @* begin
        rdata_d = 8'h00;
        case (1'b1)
            hit_code: begin
                rdata_d = code_word_image;
            end
            hit_alarm: begin
                rdata_d = alarm_image;
            end
            hit_link: begin
                rdata_d = link_image;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // read data holds until the next read
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_i) begin
                rdata_o <= rdata_d;
            end
        end
    end

    // registered interrupt output
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= irq_d;
        end
    end
endmodule // rx_alarm_link_irq

// *** tb/host.sv ***
// Purpose: host bus; Assumes: negedge drive; Notes: one access a call
`timescale 1ns/10ps
module host (
    input wire core_clk_i,
    input wire [7:0] rdata_i,
    output reg [7:0] addr_o, wdata_o,
    output reg wr_o, rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
    task acc(input w, input [7:0] a, d, output [7:0] q);
        @(negedge core_clk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
        @(negedge core_clk_i);
        {wr_o, rd_o} = 2'h0;
        q = rdata_i;
    endtask
endmodule // host

// *** tb/irq_chk_assertions.sv ***
// Purpose: port checks; Assumes: one clock; Notes: bound below
`timescale 1ns/10ps
module irq_chk (
    input wire core_clk_i, rst_i, clk_en_i, cbit_parity_i, rd_i, irq_o, link_run_o,
    input wire [7:0] addr_i, rdata_o,
    input wire [4:0] search_en_o
);
    wire r = rd_i & clk_en_i;
    wire nc = !cbit_parity_i & clk_en_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    chk_irq_gate: assert property (nc |=> !irq_o) else $error("irq");
    chk_run_gate: assert property (nc |=> !link_run_o) else $error("run");
    chk_search_init: assert property ($fell(rst_i) |-> &search_en_o) else $error("init");
    chk_run_init: assert property ($fell(rst_i) |-> !link_run_o) else $error("init");
    chk_rdata_hold: assert property (!$stable(rdata_o) |-> $past(r)) else $error("hold");
    chk_unmapped_read: assert property (r && addr_i > 8'h14 |=> !rdata_o) else $error("map");
    chk_word_pad: assert property (r && addr_i == 8'h12 |=> !rdata_o[7]) else $error("pad");
    chk_alarm_pad: assert property (r && addr_i == 8'h13 |=> !rdata_o[7:5]) else $error("pad");
    cover property (r);
    cover property ($rose(irq_o));
    cover property ($rose(link_run_o));
endmodule // irq_chk
bind rx_alarm_link_irq irq_chk chk_inst (.*);

// *** tb/tb.sv ***
// Purpose: bench; Assumes: 50 MHz; Notes: fixed waits
`timescale 1ns/10ps
module tb;
    logic core_clk_i = 0, rst_i = 1, clk_en_i = 1, cbit_parity_i = 1, code_valid_i = 0, link_msg_i = 0;
    logic wr_i, rd_i, irq_o, link_run_o;
    logic [5:0] code_word_i = 6'h01;
    logic [7:0] addr_i, wdata_i, rdata_o, q;
    logic [4:0] search_en_o;
    int error_cnt = 0, cmp_count = 0;
    rx_alarm_link_irq rx_alarm_link_irq_inst (.*);
    host host_inst (.core_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    initial forever #10 core_clk_i = ~core_clk_i;
    task ck(input [7:0] v, e);
        cmp_count++;
        if (v !== e) begin
            error_cnt++;
            $display("Error %0t: bad value", $time);
        end
    endtask
    task rc(input [7:0] a, e);
        host_inst.acc(0, a, 8'h00, q);
        ck(q, e);
    endtask
    task w3;
        repeat (3) @(negedge core_clk_i);
    endtask
    task finish_test;
        $display("cmp %0d err %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge core_clk_i);
        rst_i = 0;
        rc(8'h14, 8'hF8);
        host_inst.acc(1, 8'h13, 8'h0A, q);
        code_valid_i = 1;
        w3;
        ck({7'h00, irq_o}, 8'h01);
        rc(8'h13, 8'h1B);
        code_valid_i = 0;
        w3;
        ck({7'h00, irq_o}, 8'h01);
        rc(8'h13, 8'h0E);
        rc(8'h12, 8'h40);
        ck({7'h00, irq_o}, 8'h00);
        $display("alarm done");
        host_inst.acc(1, 8'h14, 8'h06, q);
        link_msg_i = 1;
        @(negedge core_clk_i);
        link_msg_i = 0;
        w3;
        ck({search_en_o, irq_o, 1'b0, link_run_o}, 8'h05);
        rc(8'h14, 8'h07);
        w3;
        ck({7'h00, irq_o}, 8'h00);
        clk_en_i = 0;
        host_inst.acc(1, 8'h14, 8'hFF, q);
        clk_en_i = 1;
        rc(8'h14, 8'h06);
        rc(8'h20, 8'h00);
        cbit_parity_i = 0;
        code_valid_i = 1;
        w3;
        ck({irq_o, 6'h00, link_run_o}, 8'h00);
        rc(8'h13, 8'h0A);
        $display("link done");
        finish_test;
    end
endmodule // tb
